// file: hdl/smon_pkg.sv
// Package of constants and types for the supply monitor, status and power sequencer
package smon_pkg;

  localparam logic [7:0] BASE_BLOCKING_HI = 8'h02;
  localparam logic [7:0] BASE_NONBLOCK_HI = 8'h03;
  localparam logic [7:0] OFF_ISR_LO = 8'h00;
  localparam logic [7:0] OFF_ISR_HI = 8'h01;
  localparam logic [7:0] OFF_VCR = 8'h04;
  localparam logic [7:0] OFF_VSR = 8'h05;

  localparam int NUM_WARN = 5;
  localparam int BIT_REG_OV = 4;
  localparam int BIT_HOT = 3;
  localparam int BIT_HIGH_VOLT = 2;
  localparam int BIT_LOW_VOLT = 1;
  localparam int BIT_LOW_BATT = 0;
  localparam int ISR_SUPPLY_BIT = 0;

  localparam logic [4:0] VCR_RESET = 5'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  typedef enum {
    SMON_REG_NONE,
    SMON_REG_ISR_LO,
    SMON_REG_ISR_HI,
    SMON_REG_VCR,
    SMON_REG_VSR
  } smon_reg_e;

  // One register access from the die-to-die target, one cycle wide
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } smon_bus_req_s;

  // Live comparator outputs from the analog side
  typedef struct packed {
    logic core_overvolt;
    logic io_overvolt;
    logic hot_cond;
    logic high_volt_cond;
    logic low_volt_cond;
    logic low_batt_cond;
  } smon_sense_s;

  // Threshold comparators that steer the power sequence
  typedef struct packed {
    logic io_supply_ok;
    logic core_supply_ok;
  } smon_rail_s;

endpackage : smon_pkg

// file: hdl/smon_flag_bank.sv
// Latched supply warning flags with edge set and clear on status read
`timescale 1ns/1ps
module smon_flag_bank #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Conditions and controls
  input wire logic [WIDTH-1:0] cond,
  input wire logic [WIDTH-1:0] enable,
  input wire logic clear,
  // Flags
  output logic [WIDTH-1:0] flags
);
  import smon_pkg::*;

  logic [WIDTH-1:0] cond_prev_r;
  logic [WIDTH-1:0] flag_r;
  logic [WIDTH-1:0] flag_nxt;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // A new event in the clearing cycle is kept
      always_comb begin
        flag_nxt[i] = (cond[i] & ~cond_prev_r[i] & enable[i]) | (flag_r[i] & ~clear);
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      cond_prev_r <= '0;
      flag_r <= '0;
    end else begin
      cond_prev_r <= cond;
      flag_r <= flag_nxt;
    end
  end

  assign flags = flag_r;

endmodule : smon_flag_bank

// file: hdl/smon_pwr_seq.sv
// Core regulator and reset output sequencing against the I/O supply
`timescale 1ns/1ps
module smon_pwr_seq (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Rail comparators
  input wire smon_pkg::smon_rail_s rail,
  // Regulator and reset controls
  output logic core_reg_en,
  output logic core_discharge,
  output logic reset_out_n
);
  import smon_pkg::*;

  typedef enum {SEQ_OFF, SEQ_RAMP, SEQ_RUN} smon_seq_e;

  smon_seq_e state_r;
  smon_seq_e state_nxt;
  logic en_nxt;
  logic dis_nxt;
  logic rst_n_nxt;
  logic en_r;
  logic dis_r;
  logic rst_n_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SEQ_OFF: if (rail.io_supply_ok) state_nxt = SEQ_RAMP;
      SEQ_RAMP: if (rail.core_supply_ok) state_nxt = SEQ_RUN;
      SEQ_RUN: if (!rail.core_supply_ok) state_nxt = SEQ_RAMP;
      default: state_nxt = SEQ_OFF;
    endcase
    if (!rail.io_supply_ok) state_nxt = SEQ_OFF;
    en_nxt = (state_nxt != SEQ_OFF);
    dis_nxt = (state_nxt == SEQ_OFF);
    rst_n_nxt = (state_nxt == SEQ_RUN);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= SEQ_OFF;
      en_r <= 1'b0;
      dis_r <= 1'b1;
      rst_n_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      en_r <= en_nxt;
      dis_r <= dis_nxt;
      rst_n_r <= rst_n_nxt;
    end
  end

  assign core_reg_en = en_r;
  assign core_discharge = dis_r;
  assign reset_out_n = rst_n_r;

endmodule : smon_pwr_seq

// file: hdl/smon_top.sv
// Supply monitor register bank, warning flags, interrupt line and power sequencer
`timescale 1ns/1ps
module smon_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register access from the die-to-die target
  input wire smon_pkg::smon_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  // Analog comparators and mode
  input wire smon_pkg::smon_sense_s sense,
  input wire smon_pkg::smon_rail_s rail,
  input wire logic normal_mode,
  // Power and interrupt outputs
  output logic core_reg_en,
  output logic core_discharge,
  output logic reset_out_n,
  output logic die_link_irq_out
);
  import smon_pkg::*;

  // Both address windows alias the same registers
  function automatic smon_reg_e smon_decode(input logic [15:0] addr);
    smon_reg_e r;
    r = SMON_REG_NONE;
    if (addr[15:8] == BASE_BLOCKING_HI || addr[15:8] == BASE_NONBLOCK_HI) begin
      case (addr[7:0])
        OFF_ISR_LO: r = SMON_REG_ISR_LO;
        OFF_ISR_HI: r = SMON_REG_ISR_HI;
        OFF_VCR: r = SMON_REG_VCR;
        OFF_VSR: r = SMON_REG_VSR;
        default: r = SMON_REG_NONE;
      endcase
    end
    return r;
  endfunction : smon_decode

  smon_reg_e acc_reg;
  logic wr_vcr;
  logic rd_vsr;

  logic [4:0] enables_r;
  logic [4:0] enables_nxt;
  logic [NUM_WARN-1:0] cond;
  logic [NUM_WARN-1:0] flags;
  logic supply_irq_summary;

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic irq_r;
  logic irq_nxt;

  // Named enable bits
  logic reg_overvolt_irq_en;
  logic hot_irq_en;
  logic high_volt_irq_en;
  logic low_volt_irq_en;
  logic low_batt_irq_en;

  assign reg_overvolt_irq_en = enables_r[BIT_REG_OV];
  assign hot_irq_en = enables_r[BIT_HOT];
  assign high_volt_irq_en = enables_r[BIT_HIGH_VOLT];
  assign low_volt_irq_en = enables_r[BIT_LOW_VOLT];
  assign low_batt_irq_en = enables_r[BIT_LOW_BATT];

  // Live warning conditions in status register order
  always_comb begin
    cond = '0;
    cond[BIT_REG_OV] = sense.core_overvolt | sense.io_overvolt;
    cond[BIT_HOT] = sense.hot_cond;
    cond[BIT_HIGH_VOLT] = sense.high_volt_cond;
    cond[BIT_LOW_VOLT] = sense.low_volt_cond;
    cond[BIT_LOW_BATT] = sense.low_batt_cond;
  end

  // Access decode
  always_comb begin
    acc_reg = smon_decode(bus_req.addr);
    wr_vcr = bus_req.wr && (acc_reg == SMON_REG_VCR);
    rd_vsr = bus_req.rd && (acc_reg == SMON_REG_VSR);
  end

  // Enable register: upper bits are not stored and read as zero
  always_comb begin
    enables_nxt = enables_r;
    if (wr_vcr) begin
      enables_nxt[BIT_REG_OV] = bus_req.wdata[BIT_REG_OV];
      enables_nxt[BIT_HOT] = bus_req.wdata[BIT_HOT];
      enables_nxt[BIT_HIGH_VOLT] = bus_req.wdata[BIT_HIGH_VOLT];
      enables_nxt[BIT_LOW_VOLT] = bus_req.wdata[BIT_LOW_VOLT];
      enables_nxt[BIT_LOW_BATT] = bus_req.wdata[BIT_LOW_BATT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      enables_r <= VCR_RESET;
    end else begin
      enables_r <= enables_nxt;
    end
  end

  // Per-warning flags, each gated by its own enable
  smon_flag_bank #(
    .WIDTH(NUM_WARN)
  ) u_flags (
    .mclk(mclk),
    .reset(reset),
    .cond(cond),
    .enable(enables_r),
    .clear(rd_vsr),
    .flags(flags)
  );

  assign supply_irq_summary = |flags;

  // Read data, interrupt line
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = bus_req.rd;
    if (bus_req.rd) begin
      rdata_nxt = 8'h00;
      case (acc_reg)
        SMON_REG_ISR_LO: rdata_nxt[ISR_SUPPLY_BIT] = supply_irq_summary;
        SMON_REG_ISR_HI: rdata_nxt = 8'h00;
        SMON_REG_VCR: rdata_nxt[4:0] = enables_r;
        SMON_REG_VSR: rdata_nxt[4:0] = cond;
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Line falls once the status read has cleared the flags
    irq_nxt = normal_mode && supply_irq_summary;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_r <= RDATA_RESET;
      rvalid_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign bus_rvalid = rvalid_r;
  assign die_link_irq_out = irq_r;

  smon_pwr_seq u_seq (
    .mclk(mclk),
    .reset(reset),
    .rail(rail),
    .core_reg_en(core_reg_en),
    .core_discharge(core_discharge),
    .reset_out_n(reset_out_n)
  );

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_io_up;
    rail.io_supply_ok;
  endsequence

  sequence s_core_up;
    rail.io_supply_ok && rail.core_supply_ok;
  endsequence

  a_core_after_io: assert property (
    $rose(core_reg_en) |-> $past(rail.io_supply_ok))
    else $error("core regulator enabled without I/O supply");

  a_core_enable_seq: assert property (
    !core_reg_en ##1 s_io_up[*2] |-> core_reg_en)
    else $error("core regulator not enabled after I/O supply came up");

  a_reset_release: assert property (
    $rose(reset_out_n) |-> $past(rail.core_supply_ok) && core_reg_en)
    else $error("reset released before core supply was up");

  a_reset_release_seq: assert property (
    core_reg_en && !reset_out_n ##1 s_core_up[*2] |-> reset_out_n)
    else $error("reset not released with both supplies up");

  a_io_drop_off: assert property (
    !rail.io_supply_ok |=> !core_reg_en && core_discharge && !reset_out_n)
    else $error("I/O supply drop did not shut core and assert reset");

  a_vcr_alias_write: assert property (
    wr_vcr |=> enables_r == $past(bus_req.wdata[4:0]))
    else $error("enable register write lost through an alias window");

  a_ov_gated: assert property (
    ($rose(cond[BIT_REG_OV]) && reg_overvolt_irq_en && !rd_vsr) ##1 1 |-> flags[BIT_REG_OV])
    else $error("overvoltage flag not set while enabled");

  a_hot_masked: assert property (
    (!flags[BIT_HOT] && !hot_irq_en) |=> !flags[BIT_HOT])
    else $error("high temperature flag set while disabled");

  a_hv_gated: assert property (
    ($rose(cond[BIT_HIGH_VOLT]) && high_volt_irq_en) |=> flags[BIT_HIGH_VOLT])
    else $error("high voltage flag not set while enabled");

  a_lv_masked: assert property (
    (!flags[BIT_LOW_VOLT] && !low_volt_irq_en) |=> !flags[BIT_LOW_VOLT])
    else $error("low voltage flag set while disabled");

  a_lb_gated: assert property (
    ($rose(cond[BIT_LOW_BATT]) && low_batt_irq_en) |=> flags[BIT_LOW_BATT])
    else $error("low battery flag not set while enabled");

  a_ov_read_clear: assert property (
    (rd_vsr && !$rose(cond[BIT_REG_OV])) |=> !flags[BIT_REG_OV])
    else $error("status read left overvoltage flag set");

  a_hot_read_clear: assert property (
    (rd_vsr && !$rose(cond[BIT_HOT])) |=> !flags[BIT_HOT])
    else $error("status read left high temperature flag set");

  a_hv_read_clear: assert property (
    (rd_vsr && !$rose(cond[BIT_HIGH_VOLT])) |=> !flags[BIT_HIGH_VOLT])
    else $error("status read left high voltage flag set");

  a_lv_read_clear: assert property (
    (rd_vsr && !$rose(cond[BIT_LOW_VOLT])) |=> !flags[BIT_LOW_VOLT])
    else $error("status read left low voltage flag set");

  a_lb_read_clear: assert property (
    (rd_vsr && !$rose(cond[BIT_LOW_BATT])) |=> !flags[BIT_LOW_BATT])
    else $error("status read left low battery flag set");

  a_status_live: assert property (
    rd_vsr |=> bus_rvalid && bus_rdata == {3'b000, $past(cond)})
    else $error("status read did not return live conditions");

  a_isr_summary: assert property (
    (bus_req.rd && acc_reg == SMON_REG_ISR_LO) |=> bus_rdata == {7'h00, $past(|flags)})
    else $error("source register summary bit wrong");

  a_irq_pending: assert property (
    (normal_mode && |flags) |=> die_link_irq_out)
    else $error("interrupt line low with a pending flag");

  a_irq_normal_only: assert property (
    !normal_mode |=> !die_link_irq_out)
    else $error("interrupt line high outside normal mode");

  a_flag_holds: assert property (
    (flags[BIT_HOT] && !rd_vsr) |=> flags[BIT_HOT])
    else $error("flag dropped without a status read");

  a_ov_masked: assert property (
    (!flags[BIT_REG_OV] && !reg_overvolt_irq_en) |=> !flags[BIT_REG_OV])
    else $error("overvoltage flag set while disabled");

  a_hot_gated: assert property (
    ($rose(cond[BIT_HOT]) && hot_irq_en) |=> flags[BIT_HOT])
    else $error("high temperature flag not set while enabled");

  a_hv_masked: assert property (
    (!flags[BIT_HIGH_VOLT] && !high_volt_irq_en) |=> !flags[BIT_HIGH_VOLT])
    else $error("high voltage flag set while disabled");

  a_lv_gated: assert property (
    ($rose(cond[BIT_LOW_VOLT]) && low_volt_irq_en) |=> flags[BIT_LOW_VOLT])
    else $error("low voltage flag not set while enabled");

  a_lb_masked: assert property (
    (!flags[BIT_LOW_BATT] && !low_batt_irq_en) |=> !flags[BIT_LOW_BATT])
    else $error("low battery flag set while disabled");

  a_ov_holds: assert property (
    (flags[BIT_REG_OV] && !rd_vsr) |=> flags[BIT_REG_OV])
    else $error("overvoltage flag dropped without a status read");

  a_hv_holds: assert property (
    (flags[BIT_HIGH_VOLT] && !rd_vsr) |=> flags[BIT_HIGH_VOLT])
    else $error("high voltage flag dropped without a status read");

  a_lv_holds: assert property (
    (flags[BIT_LOW_VOLT] && !rd_vsr) |=> flags[BIT_LOW_VOLT])
    else $error("low voltage flag dropped without a status read");

  a_lb_holds: assert property (
    (flags[BIT_LOW_BATT] && !rd_vsr) |=> flags[BIT_LOW_BATT])
    else $error("low battery flag dropped without a status read");

  a_lb_needs_edge: assert property (
    (!$past(reset) && !flags[BIT_LOW_BATT] && !$rose(cond[BIT_LOW_BATT])) |=> !flags[BIT_LOW_BATT])
    else $error("low battery flag set without a new condition");

  a_discharge_off: assert property (
    core_discharge != core_reg_en)
    else $error("discharge and regulator enable not complementary");

  a_reset_needs_core: assert property (
    reset_out_n |-> core_reg_en)
    else $error("reset released with core regulator off");

  a_core_drop_reset: assert property (
    (rail.io_supply_ok && !rail.core_supply_ok) |=> !reset_out_n && core_reg_en)
    else $error("core supply loss did not assert reset");

  a_rvalid_follows: assert property (
    bus_req.rd |=> bus_rvalid)
    else $error("read not answered");

  a_rvalid_idle: assert property (
    !bus_req.rd |=> !bus_rvalid)
    else $error("read answer without a read");

  a_vcr_readback: assert property (
    (bus_req.rd && acc_reg == SMON_REG_VCR) |=> bus_rdata == {3'b000, $past(enables_r)})
    else $error("enable register read back wrong");

  a_isr_hi_zero: assert property (
    (bus_req.rd && acc_reg == SMON_REG_ISR_HI) |=> bus_rdata == 8'h00)
    else $error("source high byte not zero");

  a_unmapped_zero: assert property (
    (bus_req.rd && acc_reg == SMON_REG_NONE) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_enables_hold: assert property (
    !wr_vcr |=> $stable(enables_r))
    else $error("enable register changed without a write");

  a_irq_clears: assert property (
    (!normal_mode || !(|flags)) |=> !die_link_irq_out)
    else $error("interrupt line high without a pending flag");

endmodule : smon_top

// file: verification/smon_initiator.sv
// Die-to-die initiator model issuing single-byte register cycles
`timescale 1ns/1ps
module smon_initiator (
  // Clock
  input wire logic mclk,
  // Register cycle
  output smon_pkg::smon_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid
);
  import smon_pkg::*;

  initial begin
    bus_req = '0;
  end

  // Idle address and data show the inverse so a stale value never decodes
  task automatic release_bus();
    bus_req.wr = 1'b0;
    bus_req.rd = 1'b0;
    bus_req.addr = ~bus_req.addr;
    bus_req.wdata = ~bus_req.wdata;
  endtask : release_bus

  // Trimming is assumed loaded before overvoltage is trusted
  task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
    @(negedge mclk);
    bus_req = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(negedge mclk);
    release_bus();
  endtask : write_reg

  task automatic read_reg(input logic [15:0] addr, output logic [7:0] data, output logic valid);
    @(negedge mclk);
    bus_req = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: ~bus_req.wdata};
    @(negedge mclk);
    release_bus();
    valid = bus_rvalid;
    data = bus_rdata;
  endtask : read_reg
endmodule : smon_initiator

// file: verification/supply_monitor_status_and_sequencer_bench.sv
// Self-checking bench for the supply monitor register bank and sequencer
`timescale 1ns/1ps
module supply_monitor_status_and_sequencer_bench;
  import smon_pkg::*;

  logic mclk, reset, normal_mode, bus_rvalid;
  logic core_reg_en, core_discharge, reset_out_n, die_link_irq_out;
  smon_sense_s sense;
  smon_rail_s rail;
  smon_bus_req_s bus_req;
  logic [7:0] bus_rdata, d;
  logic [4:0] c, en;
  int mismatches, samples_checked, cycles, rnd;

  smon_top DUT (.mclk(mclk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .sense(sense), .rail(rail), .normal_mode(normal_mode),
    .core_reg_en(core_reg_en), .core_discharge(core_discharge), .reset_out_n(reset_out_n),
    .die_link_irq_out(die_link_irq_out));

  smon_initiator INIT (.mclk(mclk), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));

  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 4000) begin
      mismatches++;
      $display("ERROR at %0t: run did not finish in time", $time);
      report_and_stop();
    end
  end

  function automatic smon_sense_s mk_sense(input logic [4:0] v, input logic via_io);
    mk_sense = '{core_overvolt: v[4] & ~via_io, io_overvolt: v[4] & via_io, hot_cond: v[3],
      high_volt_cond: v[2], low_volt_cond: v[1], low_batt_cond: v[0]};
  endfunction : mk_sense

  function automatic logic exp_irq(input logic [4:0] v, input logic [4:0] e, input logic m);
    exp_irq = m & (|(v & e));
  endfunction : exp_irq

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    logic ok;
    INIT.read_reg(a, d, ok);
    check(ok, 1'b1, "read answer");
    check(d, exp, what);
  endtask : rd

  task automatic pwr(input logic e, input logic dis, input logic rn);
    check({core_reg_en, core_discharge, reset_out_n}, {e, dis, rn}, "power outputs");
  endtask : pwr

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    normal_mode = 1'b1;
    sense = '0;
    rail = '0;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    rnd = $urandom(97732);
    wait_n(2);
    reset = 1'b0;
    pwr(1'b0, 1'b1, 1'b0);
    check(die_link_irq_out, 1'b0, "irq after reset");
    rd(16'h0204, 8'h00, "enables reset value");
    $display("Test reset done");

    // Core already good while I/O is low must not start anything
    rail = '{io_supply_ok: 1'b0, core_supply_ok: 1'b1};
    wait_n(2);
    pwr(1'b0, 1'b1, 1'b0);
    rail.io_supply_ok = 1'b1;
    wait_n(1);
    pwr(1'b1, 1'b0, 1'b0);
    wait_n(1);
    pwr(1'b1, 1'b0, 1'b1);
    rail.core_supply_ok = 1'b0;
    wait_n(1);
    pwr(1'b1, 1'b0, 1'b0);
    rail.core_supply_ok = 1'b1;
    wait_n(2);
    rail.io_supply_ok = 1'b0;
    wait_n(1);
    pwr(1'b0, 1'b1, 1'b0);
    rail.io_supply_ok = 1'b1;
    wait_n(3);
    pwr(1'b1, 1'b0, 1'b1);
    $display("Test power sequence done");

    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      rnd = $urandom % 2;
      INIT.write_reg({(rnd == 1) ? 8'h03 : 8'h02, 8'h04}, d);
      rd({(rnd == 1) ? 8'h02 : 8'h03, 8'h04}, d & 8'h1F, "enables alias");
    end
    INIT.write_reg(16'h0205, 8'hFF);
    INIT.write_reg(16'h0300, 8'hFF);
    rd(16'h0304, d & 8'h1F, "enables after ignored writes");
    rd(16'h0210, 8'h00, "unmapped read");
    rd(16'h0201, 8'h00, "source high byte");
    $display("Test register access done");

    for (int i = 0; i < 5; i++) begin
      INIT.write_reg(16'h0204, 8'h01 << i);
      sense = mk_sense(5'h01 << i, 1'b0);
      wait_n(3);
      check(die_link_irq_out, 1'b1, "enabled warning irq");
      rd(16'h0200, 8'h01, "source summary");
      rd(16'h0205, 8'h01 << i, "status live bit");
      wait_n(1);
      check(die_link_irq_out, 1'b0, "irq after status read");
      INIT.write_reg(16'h0304, ~(8'h01 << i) & 8'h1F);
      sense = '0;
      wait_n(1);
      sense = mk_sense(5'h01 << i, 1'b1);
      wait_n(3);
      check(die_link_irq_out, 1'b0, "disabled warning irq");
      INIT.write_reg(16'h0204, 8'h1F);
      wait_n(3);
      check(die_link_irq_out, 1'b0, "standing warning after enable");
      rd(16'h0305, 8'h01 << i, "status via second window");
      sense = '0;
    end
    $display("Test single warnings done");

    for (int i = 0; i < 10; i++) begin
      en = 5'($urandom);
      c = 5'($urandom);
      INIT.write_reg(16'h0204, {3'h0, en});
      normal_mode = 1'($urandom);
      sense = mk_sense(c, 1'($urandom));
      wait_n(3);
      check(die_link_irq_out, exp_irq(c, en, normal_mode), "irq by mode");
      normal_mode = 1'b1;
      wait_n(2);
      check(die_link_irq_out, exp_irq(c, en, 1'b1), "irq in normal mode");
      rd(16'h0200, {7'h00, |(c & en)}, "source summary");
      rd(16'h0205, {3'h0, c}, "status");
      wait_n(1);
      check(die_link_irq_out, 1'b0, "irq cleared");
      sense = '0;
      wait_n(1);
    end
    $display("Test random warnings done");
    report_and_stop();
  end
endmodule : supply_monitor_status_and_sequencer_bench
